// ---- fpce_map.vh ----
// constants for the flash program command executive
`ifndef FPCE_MAP_VH
`define FPCE_MAP_VH
// op codes
`define FPCE_OP_READ        16'h0001
`define FPCE_OP_PROGRAM     16'h0002
`define FPCE_OP_WORD_PROG   16'h0003
`define FPCE_OP_CHIP_ERASE  16'h0004
`define FPCE_OP_PAGE_ERASE  16'h0005
`define FPCE_OP_BLANK_CHECK 16'h0006
`define FPCE_OP_VERSION     16'h0007
// response codes
`define FPCE_RSP_PASS       16'h0000
`define FPCE_RSP_FAIL       16'h0002
`define FPCE_RSP_NACK       16'h0003
// register byte addresses
`define FPCE_ADDR_CTRL      12'h000
`define FPCE_ADDR_STATUS    12'h004
`define FPCE_ADDR_CMD_IN    12'h008
`define FPCE_ADDR_RSP_OUT   12'h00C
`define FPCE_ADDR_VERSION   12'h010
`define FPCE_ADDR_FAILMASK  12'h014
// field positions
`define FPCE_OP_HI          31
`define FPCE_OP_LO          16
`define FPCE_CTRL_SOFTRST   0
`define FPCE_ST_RSP_VALID   0
`define FPCE_ST_CMD_READY   1
`define FPCE_ST_BUSY        2
`define FPCE_ST_ABORTED     3
`define FPCE_ST_EXEC_RESET  4
// reset values, row size and memory limit
`define FPCE_VERSION_RST    32'h00000100
`define FPCE_FAILMASK_RST   32'h00000000
`define FPCE_ROW_BYTES      32'h00000200
`define FPCE_MEM_LIMIT      32'h00000400
`endif

// ---- fpce_mem.v ----
// small flash model storage with erase and word write
`timescale 1ns/1ps
module fpce_mem #(
    parameter AW = 8
) (
    input  wire          clk_in,
    input  wire          reset_in,
    input  wire          wr_in,
    input  wire [AW-1:0] waddr_in,
    input  wire [31:0]   wdata_in,
    input  wire          erase_all_in,
    input  wire [AW-1:0] raddr_in,
    output wire [31:0]   rdata_out
);
    reg [31:0] mem_q [0:(1<<AW)-1];
    integer    i;
    assign rdata_out = mem_q[raddr_in];
    always @(posedge clk_in) begin
        for (i = 0; i < (1<<AW); i = i + 1) begin
            if (reset_in || erase_all_in) begin
                mem_q[i] <= 32'hFFFFFFFF;
            end else if (wr_in && waddr_in == i[AW-1:0]) begin
                mem_q[i] <= wdata_in;
            end
        end
    end
endmodule // fpce_mem

// ---- fpce_exec.v ----
// command interpreter of the programming executive, apb register front end
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`include "fpce_map.vh"
module fpce_exec #(
    parameter AW        = 8,
    parameter ROW_WORDS = 128
) (
    // clock and reset
    input  wire        CLK_IN,
    input  wire        RESET_IN,
    // apb slave
    input  wire        PSEL_IN,
    input  wire        PENABLE_IN,
    input  wire        PWRITE_IN,
    input  wire [11:0] PADDR_IN,
    input  wire [31:0] PWDATA_IN,
    output reg  [31:0] PRDATA_OUT,
    output reg         PREADY_OUT,
    output reg         PSLVERR_OUT,
    // protection bits reported by configuration
    input  wire        GEN_CODE_PROTECT_BIT_IN,
    input  wire        GEN_WRITE_PROTECT_BIT_IN,
    // status
    output reg         BUSY_OUT
);
    ////////////////////////////////////////////////////////////////////////////////
    localparam S_IDLE  = 8'h01;
    localparam S_ADRH  = 8'h02;
    localparam S_ADRL  = 8'h04;
    localparam S_LENH  = 8'h08;
    localparam S_LENL  = 8'h10;
    localparam S_DATA  = 8'h20;
    localparam S_WORK  = 8'h40;
    localparam S_DROP  = 8'h80;
    localparam [31:0] MEM_WORDS = 32'h1 << AW;

    function [31:0] rsp_word;
        input [15:0] hi;
        input [15:0] code;
        begin
            rsp_word = {hi, code};
        end
    endfunction

    function word_fits;
        input [31:0] byte_addr;
        begin
            word_fits = (byte_addr[31:2] < MEM_WORDS[31:2]) || (byte_addr[31:2] == 30'h0);
            word_fits = byte_addr[31:2] < MEM_WORDS[29:0];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    reg  [7:0]  state_q;
    reg  [15:0] op_q, operand_q;
    reg  [31:0] addr_q, len_q, ptr_q;
    reg  [15:0] rows_q, rowcnt_q, wcnt_q;
    reg  [31:0] rsp_q [0:3];
    reg  [1:0]  rd_q, wr_q;
    reg  [2:0]  cnt_q;
    reg  [15:0] pend_addr_q;
    reg         pend_q, failed_q, exec_rst_q, rd_hi_q;
    reg  [31:0] version_q, failmask_q;
    reg         mem_wr, mem_erase;
    reg  [31:0] mem_wdata;
    wire [31:0] mem_rdata;
    reg  [AW-1:0] mem_raddr;
    reg         blank_q;

    fpce_mem #(.AW(AW)) u_mem (
        .clk_in       (CLK_IN),
        .reset_in     (RESET_IN),
        .wr_in        (mem_wr),
        .waddr_in     (ptr_q[AW+1:2]),
        .wdata_in     (mem_wdata),
        .erase_all_in (mem_erase),
        .raddr_in     (mem_raddr),
        .rdata_out    (mem_rdata)
    );

    wire acc      = PSEL_IN && PENABLE_IN && PREADY_OUT;
    wire cmd_wr   = acc && PWRITE_IN && PADDR_IN == `FPCE_ADDR_CMD_IN;
    wire rsp_rd   = acc && !PWRITE_IN && PADDR_IN == `FPCE_ADDR_RSP_OUT;
    wire rsp_ok   = cnt_q != 3'h0;
    wire room     = cnt_q < 3'h3;
    wire cmd_rdy  = (state_q != S_WORK) && room;
    wire [31:0] row_b = ROW_WORDS * 4;
    wire [31:0] row_start = ptr_q - row_b;
    wire [31:0] row_first = ptr_q - row_b + 32'h4;
    wire [31:0] rows_all  = {len_q[31:16], PWDATA_IN[15:0]} / row_b;

    ////////////////////////////////////////////////////////////////////////////////
    // command engine plus response queue
    reg         push;
    reg  [31:0] push_w;
    always @* begin
        mem_raddr = ptr_q[AW+1:2];
        mem_wdata = PWDATA_IN;
        mem_wr    = 1'b0;
        mem_erase = 1'b0;
        if (state_q == S_DATA && cmd_wr && op_q == `FPCE_OP_PROGRAM) begin
            mem_wr = 1'b1;
        end
        // both data halves are held in the length register
        if (state_q == S_WORK && op_q == `FPCE_OP_WORD_PROG) begin
            mem_wr    = 1'b1;
            mem_wdata = len_q;
        end
        if (state_q == S_WORK && op_q == `FPCE_OP_CHIP_ERASE) begin
            mem_erase = 1'b1;
        end
        if (state_q == S_WORK && op_q == `FPCE_OP_PAGE_ERASE && operand_q != 16'h0) begin
            mem_wr    = 1'b1;
            mem_wdata = 32'hFFFFFFFF;
        end
    end

    always @(posedge CLK_IN) begin
        if (RESET_IN || exec_rst_q) begin
            state_q   <= S_IDLE;
            op_q      <= 16'h0; operand_q <= 16'h0;
            addr_q    <= 32'h0; len_q <= 32'h0; ptr_q <= 32'h0;
            rows_q    <= 16'h0; rowcnt_q <= 16'h0; wcnt_q <= 16'h0;
            rd_q      <= 2'h0; wr_q <= 2'h0; cnt_q <= 3'h0;
            pend_q    <= 1'b0; pend_addr_q <= 16'h0; failed_q <= 1'b0;
            blank_q   <= 1'b1; rd_hi_q <= 1'b0;
            exec_rst_q <= 1'b0;
        end else begin
            if (rsp_rd && rsp_ok) begin
                rd_q <= rd_q + 2'h1;
            end
            if (state_q == S_IDLE && cmd_wr && room) begin
                op_q      <= PWDATA_IN[`FPCE_OP_HI:`FPCE_OP_LO];
                operand_q <= PWDATA_IN[15:0];
                failed_q  <= 1'b0;
                blank_q   <= 1'b1;
                state_q   <= (PWDATA_IN[31:16] == `FPCE_OP_VERSION) ? S_WORK : S_ADRH;
                if (PWDATA_IN[31:16] == 16'h0 || PWDATA_IN[31:16] > `FPCE_OP_VERSION) begin
                    state_q <= S_WORK;
                end
            end else if (state_q == S_ADRH && cmd_wr) begin
                addr_q[31:16] <= PWDATA_IN[15:0];
                state_q <= S_ADRL;
            end else if (state_q == S_ADRL && cmd_wr) begin
                addr_q[15:0] <= PWDATA_IN[15:0];
                ptr_q <= {addr_q[31:16], PWDATA_IN[15:0]};
                case (op_q)
                    `FPCE_OP_PROGRAM, `FPCE_OP_BLANK_CHECK, `FPCE_OP_WORD_PROG: state_q <= S_LENH;
                    default: state_q <= S_WORK;
                endcase
                wcnt_q <= (op_q == `FPCE_OP_PAGE_ERASE) ? 16'h0 : operand_q;
            end else if (state_q == S_LENH && cmd_wr) begin
                len_q[31:16] <= PWDATA_IN[15:0];
                state_q <= S_LENL;
            end else if (state_q == S_LENL && cmd_wr) begin
                len_q[15:0] <= PWDATA_IN[15:0];
                rows_q   <= rows_all[15:0];
                rowcnt_q <= 16'h0; wcnt_q <= 16'h0;
                state_q  <= (op_q == `FPCE_OP_PROGRAM) ? S_DATA : S_WORK;
            end else if (state_q == S_DATA && cmd_wr) begin
                ptr_q  <= ptr_q + 32'h4;
                if ((PWDATA_IN & failmask_q) != 32'h0) begin
                    failed_q <= 1'b1;
                end
                if (wcnt_q == ROW_WORDS - 1) begin
                    wcnt_q   <= 16'h0;
                    rowcnt_q <= rowcnt_q + 16'h1;
                    pend_q   <= 1'b1;
                    pend_addr_q <= row_first[15:0];
                    if (failed_q || (PWDATA_IN & failmask_q) != 32'h0 || rowcnt_q + 16'h1 == rows_q) begin
                        // last or failing row answers from the work state
                        state_q <= S_WORK;
                        pend_q  <= 1'b0;
                    end
                end else begin
                    wcnt_q <= wcnt_q + 16'h1;
                end
            end else if (state_q == S_DROP) begin
                if (cmd_wr) begin
                    ptr_q <= ptr_q + 32'h4;
                    if (ptr_q + 32'h4 >= addr_q + len_q) begin
                        state_q <= S_IDLE;
                    end
                end else if (cnt_q == 3'h0) begin
                    // failure answer taken, the probe has stopped sending
                    state_q <= S_IDLE;
                end
            end else if (state_q == S_WORK) begin
                if (op_q == `FPCE_OP_READ && wcnt_q != 16'h0) begin
                    if (!word_fits(ptr_q)) begin
                        exec_rst_q <= 1'b1;
                    end else if (room && rd_hi_q) begin
                        ptr_q  <= ptr_q + 32'h4;
                        wcnt_q <= wcnt_q - 16'h1;
                    end
                    rd_hi_q <= room ? !rd_hi_q : rd_hi_q;
                end else if (op_q == `FPCE_OP_PAGE_ERASE && operand_q != 16'h0) begin
                    ptr_q <= ptr_q + 32'h4;
                    if (wcnt_q == ROW_WORDS - 1) begin
                        wcnt_q    <= 16'h0;
                        operand_q <= operand_q - 16'h1;
                    end else begin
                        wcnt_q <= wcnt_q + 16'h1;
                    end
                end else if (op_q == `FPCE_OP_BLANK_CHECK && len_q != 32'h0) begin
                    if (mem_rdata != 32'hFFFFFFFF || !word_fits(ptr_q)) begin
                        blank_q <= 1'b0;
                    end
                    ptr_q <= ptr_q + 32'h4;
                    len_q <= (len_q > 32'h4) ? len_q - 32'h4 : 32'h0;
                end else if (op_q == `FPCE_OP_PROGRAM) begin
                    if (room) begin
                        state_q <= (failed_q && ptr_q < addr_q + len_q) ? S_DROP : S_IDLE;
                    end
                end else if (room) begin
                    state_q <= S_IDLE;
                end
            end
            if (push) begin
                wr_q <= wr_q + 2'h1;
            end
            cnt_q <= cnt_q + {2'h0, push} - {2'h0, rsp_rd && rsp_ok};
            if (push) begin
                rsp_q[wr_q] <= push_w;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // response generation
    always @* begin
        push   = 1'b0;
        push_w = 32'h0;
        if (state_q == S_DATA && cmd_wr && op_q == `FPCE_OP_PROGRAM && wcnt_q == ROW_WORDS - 1 && pend_q) begin
            push   = 1'b1;
            push_w = rsp_word(pend_addr_q, `FPCE_RSP_PASS);
        end else if (state_q == S_WORK && op_q == `FPCE_OP_PROGRAM && room) begin
            push   = 1'b1;
            push_w = rsp_word(row_start[15:0], failed_q ? `FPCE_RSP_FAIL : `FPCE_RSP_PASS);
        end else if (state_q == S_ADRL && cmd_wr && op_q == `FPCE_OP_READ) begin
            // read header goes ahead of the data words
            push   = 1'b1;
            push_w = rsp_word(op_q, `FPCE_RSP_PASS);
        end else if (state_q == S_WORK && op_q == `FPCE_OP_READ && room && wcnt_q != 16'h0 &&
                     word_fits(ptr_q)) begin
            push   = rd_hi_q;
            push_w = mem_rdata;
        end else if (state_q == S_WORK && room && !(op_q == `FPCE_OP_PAGE_ERASE && operand_q != 16'h0) &&
                     !(op_q == `FPCE_OP_BLANK_CHECK && len_q != 32'h0) && op_q != `FPCE_OP_READ) begin
            push = 1'b1;
            case (op_q)
                `FPCE_OP_VERSION: push_w = rsp_word(op_q, version_q[15:0]);
                `FPCE_OP_BLANK_CHECK:
                    push_w = rsp_word(op_q, (blank_q && GEN_CODE_PROTECT_BIT_IN && GEN_WRITE_PROTECT_BIT_IN) ?
                                      `FPCE_RSP_PASS : `FPCE_RSP_FAIL);
                `FPCE_OP_READ, `FPCE_OP_WORD_PROG, `FPCE_OP_CHIP_ERASE, `FPCE_OP_PAGE_ERASE:
                    push_w = rsp_word(op_q, `FPCE_RSP_PASS);
                default: push_w = rsp_word(op_q, `FPCE_RSP_NACK);
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // apb registers, zero wait state answers
    always @(posedge CLK_IN) begin
        if (RESET_IN) begin
            PRDATA_OUT  <= 32'h0;
            PREADY_OUT  <= 1'b0;
            PSLVERR_OUT <= 1'b0;
            BUSY_OUT    <= 1'b0;
            version_q   <= `FPCE_VERSION_RST;
            failmask_q  <= `FPCE_FAILMASK_RST;
        end else begin
            BUSY_OUT    <= state_q != S_IDLE || cnt_q != 3'h0;
            PREADY_OUT  <= PSEL_IN && !PENABLE_IN;
            PSLVERR_OUT <= 1'b0;
            PRDATA_OUT  <= 32'h0;
            if (PSEL_IN && !PENABLE_IN) begin
                case (PADDR_IN)
                    `FPCE_ADDR_STATUS: PRDATA_OUT <= {27'h0, exec_rst_q, state_q == S_DROP,
                                                       state_q != S_IDLE, cmd_rdy, rsp_ok};
                    `FPCE_ADDR_RSP_OUT: PRDATA_OUT <= rsp_ok ? rsp_q[rd_q] : 32'h0;
                    `FPCE_ADDR_VERSION: PRDATA_OUT <= version_q;
                    `FPCE_ADDR_FAILMASK: PRDATA_OUT <= failmask_q;
                    `FPCE_ADDR_CTRL, `FPCE_ADDR_CMD_IN: PRDATA_OUT <= 32'h0;
                    default: PSLVERR_OUT <= 1'b1;
                endcase
            end
            // writes land at the access edge only
            if (acc && PWRITE_IN && PADDR_IN == `FPCE_ADDR_VERSION) begin
                version_q <= PWDATA_IN;
            end
            if (acc && PWRITE_IN && PADDR_IN == `FPCE_ADDR_FAILMASK) begin
                failmask_q <= PWDATA_IN;
            end
        end
    end
endmodule // fpce_exec

// ---- fpce_props.sv ----
// apb port assertions for the command executive
`timescale 1ns/1ps
module fpce_props (
    input wire logic        CLK_IN,
    input wire logic        RESET_IN,
    input wire logic        PSEL_IN,
    input wire logic        PENABLE_IN,
    input wire logic        PWRITE_IN,
    input wire logic [11:0] PADDR_IN,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic        PREADY_OUT,
    input wire logic        PSLVERR_OUT,
    input wire logic        BUSY_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (RESET_IN);
    sequence setup_s;
        PSEL_IN && !PENABLE_IN;
    endsequence
    sequence rd_done_s;
        PREADY_OUT && !PWRITE_IN;
    endsequence
    ready_after_setup_a: assert property (setup_s |=> PREADY_OUT)
        else $error("no ready after setup");
    ready_pulse_a: assert property (PREADY_OUT |=> !PREADY_OUT)
        else $error("ready longer than one cycle");
    ready_in_access_a: assert property (PREADY_OUT |-> PSEL_IN && PENABLE_IN)
        else $error("ready outside access");
    slverr_unmapped_a: assert property (PREADY_OUT && PADDR_IN > 12'h014 |-> PSLVERR_OUT)
        else $error("unmapped access not flagged");
    slverr_mapped_a: assert property (PREADY_OUT && PADDR_IN <= 12'h014 |-> !PSLVERR_OUT)
        else $error("mapped access flagged");
    ctrl_reads_zero_a: assert property (rd_done_s ##0 PADDR_IN == 12'h000 |-> PRDATA_OUT == 32'h0)
        else $error("control reads nonzero");
    busy_with_rsp_a: assert property (rd_done_s ##0 (PADDR_IN == 12'h004 && PRDATA_OUT[0]) |-> BUSY_OUT)
        else $error("unread response while idle");
    reset_quiet_a: assert property ($past(RESET_IN) |-> !BUSY_OUT && !PREADY_OUT)
        else $error("outputs active after reset");
endmodule // fpce_props
bind fpce_exec fpce_props u_props (.CLK_IN(CLK_IN), .RESET_IN(RESET_IN), .PSEL_IN(PSEL_IN),
    .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PRDATA_OUT(PRDATA_OUT),
    .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .BUSY_OUT(BUSY_OUT));

// ---- fpce_probe.sv ----
// programmer probe model: apb master feeding commands and pulling responses
`timescale 1ns/1ps
module fpce_probe (
    // clock
    input  wire logic        clk_in,
    // apb master
    output logic             psel_out = 1'b0,
    output logic             penable_out = 1'b0,
    output logic             pwrite_out = 1'b0,
    output logic [11:0]      paddr_out = 12'h000,
    output logic [31:0]      pwdata_out = 32'h0,
    input  wire logic [31:0] prdata_in,
    input  wire logic        pready_in,
    input  wire logic        pslverr_in
);
    logic [31:0] rd_q;
    logic        er_q;
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        psel_out    <= 1'b1;
        penable_out <= 1'b0;
        pwrite_out  <= w;
        paddr_out   <= a;
        pwdata_out  <= d;
        @(posedge clk_in);
        penable_out <= 1'b1;
        do @(posedge clk_in); while (pready_in !== 1'b1);
        r = prdata_in;
        e = pslverr_in;
        psel_out    <= 1'b0;
        penable_out <= 1'b0;
        // released data shows no stale value
        pwdata_out  <= ~d;
        @(posedge clk_in);
    endtask
    task automatic cmd(input logic [31:0] w);
        do xfer(1'b0, 12'h004, 32'h0, rd_q, er_q); while (rd_q[1] !== 1'b1);
        xfer(1'b1, 12'h008, w, rd_q, er_q);
    endtask
    task automatic cmd32(input logic [31:0] v);
        cmd({16'h0000, v[31:16]});
        cmd({16'h0000, v[15:0]});
    endtask
    task automatic rsp_pull();
        do xfer(1'b0, 12'h004, 32'h0, rd_q, er_q); while (rd_q[0] !== 1'b1);
        xfer(1'b0, 12'h00C, 32'h0, rd_q, er_q);
    endtask
endmodule // fpce_probe

// ---- tb_flash_program_command_executive.sv ----
// self-checking bench for the flash program command executive
`timescale 1ns/1ps
module tb_flash_program_command_executive;
    localparam int RW = 32;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        general_code_protect_bit = 1'b1;
    logic        gwp = 1'b1;
    wire         psel, pen, pwr, prdy, perr, busy;
    wire  [11:0] paddr;
    wire  [31:0] pwd, prd;
    logic [31:0] expq[$];
    logic [31:0] mem[256];
    logic [31:0] r;
    logic        e;
    integer      seed = 32'h7a942cfa;
    int          err_total = 0;
    int          n_compared = 0;
    int          cyc = 0;
    always #20 clk = ~clk;
    fpce_exec #(.AW(8), .ROW_WORDS(RW)) uut (.CLK_IN(clk), .RESET_IN(rst), .PSEL_IN(psel),
        .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwd), .PRDATA_OUT(prd),
        .PREADY_OUT(prdy), .PSLVERR_OUT(perr), .GEN_CODE_PROTECT_BIT_IN(general_code_protect_bit),
        .GEN_WRITE_PROTECT_BIT_IN(gwp), .BUSY_OUT(busy));
    fpce_probe u_probe (.clk_in(clk), .psel_out(psel), .penable_out(pen), .pwrite_out(pwr),
        .paddr_out(paddr), .pwdata_out(pwd), .prdata_in(prd), .pready_in(prdy), .pslverr_in(perr));
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        n_compared++;
        if (g !== x) begin
            err_total++;
            $display("mismatch at %0t got %h expected %h", $time, g, x);
        end
    endtask
    // watcher: every completed read at or below 0x014, except status, is matched to the oldest note
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            close_out();
        end
        if (prdy === 1'b1 && psel && !pwr && paddr != 12'h004 && paddr <= 12'h014) begin
            if (expq.size() == 0) chk(prd, 'x);
            else chk(prd, expq.pop_front());
        end
    end
    task automatic rd_exp(input logic [11:0] a, input logic [31:0] v);
        expq.push_back(v);
        u_probe.xfer(1'b0, a, 32'h0, r, e);
    endtask
    task automatic rsp(input logic [31:0] v);
        expq.push_back(v);
        u_probe.rsp_pull();
    endtask
    task automatic no_rsp();
        u_probe.xfer(1'b0, 12'h004, 32'h0, r, e);
        chk({31'h0, r[0]}, 32'h0);
    endtask
    task automatic settle();
        for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge clk);
        chk({31'h0, busy}, 32'h0);
    endtask
    task automatic erase();
        u_probe.cmd(32'h00040000);
        u_probe.cmd32(32'h0);
        rsp(32'h00040000);
        for (int i = 0; i < 256; i++) mem[i] = 32'hFFFFFFFF;
    endtask
    task automatic rdback(input logic [31:0] a, input int n);
        u_probe.cmd({16'h0001, n[15:0]});
        u_probe.cmd32(a);
        rsp(32'h00010000);
        for (int j = 0; j < n; j++) rsp(mem[a[9:2] + j]);
    endtask
    task automatic prog(input logic [31:0] b, input int n, input int bad);
        logic [31:0] w;
        logic [31:0] ra;
        logic [31:0] pa;
        u_probe.cmd(32'h0002ABCD);
        u_probe.cmd32(b);
        u_probe.cmd32(n * RW * 4);
        for (int k = 0; k < n; k++) begin
            for (int j = 0; j < RW; j++) begin
                w = $random(seed);
                if (bad >= 0) w[31] = (k == bad && j == 0);
                mem[b[9:2] + k * RW + j] = w;
                u_probe.cmd(w);
            end
            ra = b + k * RW * 4;
            pa = ra - RW * 4;
            if (k == bad) begin
                if (k > 0) rsp({pa[15:0], 16'h0000});
                rsp({ra[15:0], 16'h0002});
                return;
            end
            if (n == 1) rsp({ra[15:0], 16'h0000});
            else if (k == 0) begin
                repeat (RW) @(posedge clk);
                no_rsp();
            end else begin
                rsp({pa[15:0], 16'h0000});
                if (k == n - 1) rsp({ra[15:0], 16'h0000});
            end
        end
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_exp(12'h010, 32'h00000100);
        rd_exp(12'h014, 32'h00000000);
        rd_exp(12'h000, 32'h00000000);
        u_probe.xfer(1'b0, 12'h020, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        u_probe.cmd(32'h00070000);
        rsp(32'h00070100);
        u_probe.cmd(32'h000E0000);
        rsp(32'h000E0003);
        $display("registers and version done");
        erase();
        u_probe.cmd(32'h00060000);
        u_probe.cmd32(32'h0);
        u_probe.cmd32(32'h400);
        rsp(32'h00060000);
        gwp <= 1'b0;
        u_probe.cmd(32'h00060000);
        u_probe.cmd32(32'h0);
        u_probe.cmd32(32'h400);
        rsp(32'h00060002);
        gwp <= 1'b1;
        general_code_protect_bit <= 1'b0;
        u_probe.cmd(32'h00060000);
        u_probe.cmd32(32'h0);
        u_probe.cmd32(32'h400);
        rsp(32'h00060002);
        general_code_protect_bit <= 1'b1;
        mem[4] = $random(seed);
        u_probe.cmd(32'h00030000);
        u_probe.cmd32(32'h10);
        u_probe.cmd32(mem[4]);
        rsp(32'h00030000);
        rdback(32'h10, 1);
        u_probe.cmd(32'h00050001);
        u_probe.cmd32(32'h0);
        rsp(32'h00050000);
        mem[4] = 32'hFFFFFFFF;
        rdback(32'h10, 1);
        $display("erase and word program done");
        prog(32'h0, 1, -1);
        prog(32'h80, 2, -1);
        prog(32'h180, 4, -1);
        rdback(32'h300, 3);
        $display("multi row program done");
        erase();
        u_probe.xfer(1'b1, 12'h014, 32'h80000000, r, e);
        rd_exp(12'h014, 32'h80000000);
        prog(32'h0, 3, 1);
        u_probe.xfer(1'b1, 12'h014, 32'h0, r, e);
        settle();
        rdback(32'h0, 2);
        $display("program abort done");
        u_probe.cmd(32'h00010001);
        u_probe.cmd32(32'h400);
        settle();
        no_rsp();
        u_probe.cmd(32'h00070000);
        rsp(32'h00070100);
        $display("executive reset done");
        close_out();
    end
endmodule // tb_flash_program_command_executive
